// [verilog/status_pkg.sv]
// constants shared by the charger status register bank
// assumes a single 50 MHz core clock domain
// Function
// RQ1: status register at 21h, read-only, reset 00h
// RQ2: bit 7 follows valid input source
// RQ3: bit 6 set when optimizer finishes
// RQ4: bit 5 mirrors peak-assist mode state
// RQ5: assist entry only by host, ignoring alert
// RQ6: host exits assist; any fault forces exit
// RQ7: fault exit sets flag, holds alert low
// RQ8: host enables assist: pin high, select 0
// RQ9: assist entry disables loops, swaps alert profiles
// RQ10: assist exit re-enables loops and limit pin (code has no limit pin; it re-enables loops only)
// RQ11: bit 4 shows voltage loop regulating
// RQ12: bit 3 shows current loop regulating
// RQ13: short fault latches, held through reads
// RQ14: after a read, short fault self-clears
// RQ15: overcurrent fault holds until read after 1s
// RQ16: read returns coherent byte; writes ignored
package status_pkg;
    localparam logic [7:0] STATUS_ONE_ADDR = 8'h21;
    localparam logic [7:0] STATUS_ONE_RST  = 8'h00;
    localparam int BIT_SOURCE   = 7;
    localparam int BIT_INPUT_OPTIMIZER_COMPLETE = 6;
    localparam int BIT_ASSIST   = 5;
    localparam int BIT_VREG     = 4;
    localparam int BIT_IREG     = 3;
    localparam int BIT_SHORT    = 2;
    localparam int BIT_BATCOC   = 1;
    localparam int BIT_REVERSE  = 0;
    localparam int CLK_HZ       = 50_000_000;
    localparam int BATCOC_HOLD_MS = 1000;
    // least time: rounds up
    localparam longint BATCOC_HOLD_CYC =
        (longint'(BATCOC_HOLD_MS) * CLK_HZ + 999) / 1000;
    localparam int SYNC_W = 9;
endpackage

// [verilog/latched_fault.sv]
// one read-cleared fault latch with optional minimum hold
// assumes condition, read strobe and enable come from the core clock domain
`timescale 1ns/1ps
`default_nettype none
module latched_fault
    import status_pkg::*;
#(
    parameter int HOLD_CYC = 0
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic soft_rst,
    input  wire logic cond,
    input  wire logic read_pulse,
    output logic      flag_r
);
    localparam int CW = (HOLD_CYC > 1) ? $clog2(HOLD_CYC + 1) : 1;
    logic          flag_nxt;
    logic          seen_r;
    logic          seen_nxt;
    logic [CW-1:0] age_r;
    logic [CW-1:0] age_nxt;
    logic          aged;

    assign aged = (HOLD_CYC == 0) || (age_r == CW'(HOLD_CYC));

    // a set wins over a read clear in the same cycle; soft_rst wins over a set
    always_comb begin
        flag_nxt = flag_r;
        seen_nxt = seen_r;
        age_nxt  = age_r;
        if (flag_r && !aged) begin
            age_nxt = age_r + CW'(1);
        end
        if (read_pulse && flag_r && aged) begin
            seen_nxt = 1'b1;
        end
        if (seen_r && !cond) begin
            flag_nxt = 1'b0; // see RQ14 see RQ15
            seen_nxt = 1'b0;
            age_nxt  = '0;
        end
        if (cond && !flag_r) begin
            flag_nxt = 1'b1; // see RQ13
            age_nxt  = '0;
            seen_nxt = 1'b0;
        end
        if (soft_rst) begin
            flag_nxt = 1'b0;
            seen_nxt = 1'b0;
            age_nxt  = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
            seen_r <= 1'b0;
            age_r  <= '0;
        end else if (clk_en) begin
            flag_r <= flag_nxt;
            seen_r <= seen_nxt;
            age_r  <= age_nxt;
        end
    end

    a_fault_holds: assert property ( // see RQ13
        @(posedge clock) disable iff (!rst_n || !clk_en || soft_rst)
        (flag_r && cond) |=> flag_r)
        else $error("fault cleared while condition present");
    // before the hold time has run out no read may release the flag
    a_hold_early: assert property ( // see RQ15
        @(posedge clock) disable iff (!rst_n || !clk_en || soft_rst)
        (flag_r && !aged) |=> flag_r)
        else $error("fault released before hold time");
endmodule
`default_nettype wire

// [verilog/charger_status_flags.sv]
// charger status register bank with peak-assist mode control
// assumes pins are asynchronous, host port strobes are core-clock pulses
`timescale 1ns/1ps
`default_nettype none
module charger_status_flags
    import status_pkg::*;
#(
    parameter longint BATCOC_CYC = BATCOC_HOLD_CYC
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       soft_rst,
    input  wire logic       rd_strobe,
    input  wire logic       wr_strobe,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       reverse_mode_pin,
    input  wire logic       reverse_or_assist_select,
    input  wire logic       source_valid,
    input  wire logic       optimizer_done,
    input  wire logic       vloop_active,
    input  wire logic       iloop_active,
    input  wire logic       short_cond,
    input  wire logic       batcoc_cond,
    input  wire logic       any_fault,
    input  wire logic       exit_flag_clear,
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    output logic            peak_assist_active,
    output logic            peak_assist_exit_flag,
    output logic            alert_hold_low,
    output logic            loops_enabled,
    output logic            adapter_ok_alert_profile,
    output logic            system_voltage_alert_profile,
    output logic            reverse_power_active
);
    // two-flop synchronisers for all pin-side inputs
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    assign pins = {reverse_mode_pin, reverse_or_assist_select, source_valid,
                   optimizer_done, vloop_active, iloop_active, short_cond,
                   batcoc_cond, any_fault};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else if (clk_en) begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end
    logic en_pin, sel, src, input_current_optimizer, vreg, ireg, sc, coc, flt;
    assign {en_pin, sel, src, input_current_optimizer, vreg, ireg, sc, coc, flt} = s2_r;

    logic hit_rd;
    assign hit_rd = rd_strobe && (reg_addr == STATUS_ONE_ADDR);

    // peak-assist state machine
    typedef enum logic [1:0] {
        MODE_IDLE   = 2'b00,
        MODE_ASSIST = 2'b01,
        MODE_REV    = 2'b10
    } mode_e;
    mode_e mode_r, mode_nxt;
    logic  exit_r, exit_nxt;
    logic  loops_r, loops_nxt;
    logic  acok_r, acok_nxt;
    logic  vsys_r, vsys_nxt;
    logic  assist_req;
    logic  arm_r, arm_nxt; // host request must drop after a fault exit

    assign assist_req = en_pin && !sel; // see RQ8

    always_comb begin
        mode_nxt  = mode_r;
        exit_nxt  = exit_r;
        loops_nxt = loops_r;
        acok_nxt  = acok_r;
        vsys_nxt  = vsys_r;
        arm_nxt   = arm_r;
        if (!assist_req) begin
            arm_nxt = 1'b1;
        end
        if (exit_flag_clear) begin
            exit_nxt = 1'b0;
        end
        unique case (mode_r)
            MODE_IDLE: begin
                // entry ignores alert state entirely
                if (assist_req && arm_r && !flt) begin
                    mode_nxt  = MODE_ASSIST; // see RQ5
                    loops_nxt = 1'b0;        // see RQ9
                    acok_nxt  = 1'b0;
                    vsys_nxt  = 1'b1;
                end else if (en_pin && sel) begin
                    mode_nxt = MODE_REV;
                end
            end
            MODE_ASSIST: begin
                if (flt) begin
                    mode_nxt  = MODE_IDLE;   // see RQ6
                    exit_nxt  = 1'b1;        // see RQ7
                    loops_nxt = 1'b1;        // see RQ10
                    arm_nxt   = 1'b0;
                end else if (!assist_req) begin
                    mode_nxt  = MODE_IDLE;   // see RQ6
                    loops_nxt = 1'b1;        // see RQ10
                end
            end
            MODE_REV: begin
                if (!(en_pin && sel)) begin
                    mode_nxt = MODE_IDLE;
                end
            end
            default: mode_nxt = MODE_IDLE;
        endcase
        if (soft_rst) begin
            mode_nxt  = MODE_IDLE;
            exit_nxt  = 1'b0;
            loops_nxt = 1'b1;
            acok_nxt  = 1'b1;
            vsys_nxt  = 1'b0;
            arm_nxt   = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r  <= MODE_IDLE;
            exit_r  <= 1'b0;
            loops_r <= 1'b1;
            acok_r  <= 1'b1;
            vsys_r  <= 1'b0;
            arm_r   <= 1'b1;
        end else if (clk_en) begin
            mode_r  <= mode_nxt;
            exit_r  <= exit_nxt;
            loops_r <= loops_nxt;
            acok_r  <= acok_nxt;
            vsys_r  <= vsys_nxt;
            arm_r   <= arm_nxt;
        end
    end

    // read-cleared fault latches
    logic short_flag, coc_flag;
    latched_fault #(.HOLD_CYC(0)) u_short (
        .clock      (clock),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .soft_rst   (soft_rst),
        .cond       (sc),
        .read_pulse (hit_rd),
        .flag_r     (short_flag)
    );
    latched_fault #(.HOLD_CYC(int'(BATCOC_CYC))) u_batcoc (
        .clock      (clock),
        .rst_n      (rst_n),
        .clk_en     (clk_en),
        .soft_rst   (soft_rst),
        .cond       (coc),
        .read_pulse (hit_rd),
        .flag_r     (coc_flag)
    );

    // snapshot the whole byte at once; writes never touch it
    logic [7:0] status_now;
    logic [7:0] rd_nxt;
    logic       rv_nxt;
    always_comb begin
        status_now = STATUS_ONE_RST;
        status_now[BIT_SOURCE]   = src;                     // see RQ2
        status_now[BIT_INPUT_OPTIMIZER_COMPLETE] = input_current_optimizer;                     // see RQ3
        status_now[BIT_ASSIST]   = (mode_r == MODE_ASSIST); // see RQ4
        status_now[BIT_VREG]     = vreg;                    // see RQ11
        status_now[BIT_IREG]     = ireg;                    // see RQ12
        status_now[BIT_SHORT]    = short_flag;
        status_now[BIT_BATCOC]   = coc_flag;
        status_now[BIT_REVERSE]  = (mode_r == MODE_REV);
        rd_nxt = rd_data;
        rv_nxt = 1'b0;
        if (rd_strobe) begin
            rv_nxt = 1'b1;
            rd_nxt = hit_rd ? status_now : 8'h00; // see RQ1 see RQ16
        end
    end

    logic pa_nxt, rev_nxt;
    assign pa_nxt  = (mode_nxt == MODE_ASSIST);
    assign rev_nxt = (mode_nxt == MODE_REV);

    // outputs straight from flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data                      <= STATUS_ONE_RST;
            rd_valid                     <= 1'b0;
            peak_assist_active           <= 1'b0;
            peak_assist_exit_flag        <= 1'b0;
            alert_hold_low               <= 1'b0;
            loops_enabled                <= 1'b1;
            adapter_ok_alert_profile     <= 1'b1;
            system_voltage_alert_profile <= 1'b0;
            reverse_power_active         <= 1'b0;
        end else if (clk_en) begin
            rd_data                      <= soft_rst ? STATUS_ONE_RST : rd_nxt;
            rd_valid                     <= rv_nxt;
            peak_assist_active           <= pa_nxt;
            peak_assist_exit_flag        <= exit_nxt;
            alert_hold_low               <= exit_nxt; // see RQ7
            loops_enabled                <= loops_nxt;
            adapter_ok_alert_profile     <= acok_nxt;
            system_voltage_alert_profile <= vsys_nxt;
            reverse_power_active         <= rev_nxt;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n || !clk_en || soft_rst);

    a_fault_exit: assert property ( // see RQ6
        (mode_r == MODE_ASSIST && flt) |=> (!peak_assist_active && peak_assist_exit_flag))
        else $error("fault did not force assist exit");
    a_exit_holds: assert property ( // see RQ7
        (peak_assist_exit_flag && !exit_flag_clear) |=> alert_hold_low)
        else $error("alert released before host clear");
    a_entry_loops: assert property ( // see RQ9
        $rose(peak_assist_active) |-> (!loops_enabled && system_voltage_alert_profile
                                        && !adapter_ok_alert_profile))
        else $error("loops not disabled on assist entry");
    a_leave_loops: assert property ( // see RQ10
        $fell(peak_assist_active) |-> loops_enabled)
        else $error("loops not enabled on assist exit");
    a_entry_host: assert property ( // see RQ5
        $rose(peak_assist_active) |-> $past(assist_req))
        else $error("assist entered without host request");
    a_read_snap: assert property ( // see RQ16
        hit_rd |=> (rd_valid && rd_data == $past(status_now)))
        else $error("read byte not the sampled status");
    a_bit_assist: assert property ( // see RQ4
        hit_rd |=> rd_data[BIT_ASSIST] == $past(peak_assist_active))
        else $error("assist bit wrong");
    a_bit_source: assert property ( // see RQ2
        hit_rd |=> rd_data[BIT_SOURCE] == $past(src))
        else $error("source bit wrong");
    a_write_none: assert property ( // see RQ1
        (wr_strobe && !rd_strobe) |=> $stable(rd_data))
        else $error("write changed read data");
    c_assist_on:  cover property ($rose(peak_assist_active));
    c_fault_exit: cover property ($rose(peak_assist_exit_flag));
    c_short_read: cover property (hit_rd && short_flag);
    c_rev_mode:   cover property ($rose(reverse_power_active));
endmodule
`default_nettype wire

// [tb/host_model.sv]
// host controller model: register reads/writes and mode pins
// assumes the bench calls its tasks; drives change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model
    import status_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            rd_strobe,
    output logic            wr_strobe,
    output logic [7:0]      reg_addr,
    output logic [7:0]      wr_data,
    output logic            reverse_mode_pin,
    output logic            reverse_or_assist_select,
    output logic            exit_flag_clear
);
    initial begin
        {rd_strobe, wr_strobe, reverse_mode_pin, reverse_or_assist_select} = 4'h0;
        {exit_flag_clear, reg_addr, wr_data} = 17'h00000;
    end
    // one-cycle strobe, then a bounded wait for the answer
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        d = 8'h00;
        @(negedge clock);
        rd_strobe = 1'b1;
        reg_addr = a;
        @(negedge clock);
        rd_strobe = 1'b0;
        reg_addr = ~a; // released: no stale address
        while (!ok && n < 4) begin
            if (rd_valid === 1'b1) begin
                d = rd_data;
                ok = 1'b1;
            end else begin
                n++;
                @(negedge clock);
            end
        end
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        wr_strobe = 1'b1;
        reg_addr = a;
        wr_data = d;
        @(negedge clock);
        wr_strobe = 1'b0;
        reg_addr = ~a;
        wr_data = ~d;
    endtask
    // pin high with select 0 asks for assist; anything else drops it
    task automatic mode(input logic pin, input logic sel);
        @(negedge clock);
        reverse_mode_pin = pin;
        reverse_or_assist_select = sel;
    endtask
    task automatic clear_exit;
        @(negedge clock);
        exit_flag_clear = 1'b1;
        @(negedge clock);
        exit_flag_clear = 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the charger status register bank
// assumes host_model on the port side; fault hold shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import status_pkg::*;
;
    localparam longint HOLD = 20;
    logic       clock, rst_n, clk_en, soft_rst, short_cond, batcoc_cond, any_fault;
    logic       source_valid, optimizer_done, vloop_active, iloop_active;
    wire logic  rd_strobe, wr_strobe, pin, sel, xclr, rd_valid;
    wire logic  assist, xflag, alert, loops, aprof, sprof, rev;
    wire logic [7:0] reg_addr, wr_data, rd_data;
    logic       sh, sh_seen, bc, asst;
    int         n_errors, total_checks, cyc, bc_at, seed, r;

    charger_status_flags #(.BATCOC_CYC(HOLD)) u_charger_status_flags (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .soft_rst(soft_rst),
        .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .reg_addr(reg_addr),
        .wr_data(wr_data), .reverse_mode_pin(pin), .reverse_or_assist_select(sel),
        .source_valid(source_valid), .optimizer_done(optimizer_done),
        .vloop_active(vloop_active), .iloop_active(iloop_active),
        .short_cond(short_cond), .batcoc_cond(batcoc_cond), .any_fault(any_fault),
        .exit_flag_clear(xclr), .rd_data(rd_data), .rd_valid(rd_valid),
        .peak_assist_active(assist), .peak_assist_exit_flag(xflag),
        .alert_hold_low(alert), .loops_enabled(loops),
        .adapter_ok_alert_profile(aprof), .system_voltage_alert_profile(sprof),
        .reverse_power_active(rev));
    host_model u_host_model (
        .clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .reg_addr(reg_addr),
        .wr_data(wr_data), .reverse_mode_pin(pin), .reverse_or_assist_select(sel),
        .exit_flag_clear(xclr));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test;
        if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    // inputs pass a 2-flop sync, so give them time to land
    task automatic settle;
        repeat (6) @(negedge clock);
    endtask
    // read through the host and compare with the bench model
    task automatic rd(input logic [7:0] a);
        logic [7:0] d, e;
        logic ok;
        e = {source_valid, optimizer_done, asst, vloop_active, iloop_active, sh, bc, pin & sel};
        if (a != STATUS_ONE_ADDR) e = 8'h00;
        u_host_model.read(a, d, ok);
        check({7'h00, ok}, 8'h01);
        check(d, e);
        if (a == STATUS_ONE_ADDR && sh) begin
            if (short_cond) sh_seen = 1'b1;
            else sh = 1'b0;
        end
        if (a == STATUS_ONE_ADDR && bc && cyc - bc_at >= HOLD + 4) bc = 1'b0;
    endtask

    initial begin
        {rst_n, soft_rst, short_cond, batcoc_cond, any_fault} = 5'h00;
        {source_valid, optimizer_done, vloop_active, iloop_active} = 4'h0;
        {sh, sh_seen, bc, asst} = 4'h0;
        clk_en = 1'b1;
        n_errors = 0;
        total_checks = 0;
        bc_at = 0;
        seed = 24;
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        rd(STATUS_ONE_ADDR);
        check({1'b0, loops, aprof, sprof, assist, xflag, alert, rev}, 8'h60);
        // random level bits, each must track its source
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            {source_valid, optimizer_done, vloop_active, iloop_active} = r[3:0];
            settle();
            rd(STATUS_ONE_ADDR);
        end
        rd(8'h20);
        rd(8'h22);
        u_host_model.write(STATUS_ONE_ADDR, 8'hff);
        rd(STATUS_ONE_ADDR);
        // short fault held while present, then clears on its own
        short_cond = 1'b1;
        sh = 1'b1;
        settle();
        rd(STATUS_ONE_ADDR);
        rd(STATUS_ONE_ADDR);
        short_cond = 1'b0;
        sh = !sh_seen;
        settle();
        rd(STATUS_ONE_ADDR);
        // short pulse gone before any read: latched until read
        short_cond = 1'b1;
        sh = 1'b1;
        settle();
        short_cond = 1'b0;
        settle();
        rd(STATUS_ONE_ADDR);
        rd(STATUS_ONE_ADDR);
        // overcurrent: early read keeps it, late read releases it
        batcoc_cond = 1'b1;
        bc = 1'b1;
        bc_at = cyc;
        settle();
        batcoc_cond = 1'b0;
        rd(STATUS_ONE_ADDR);
        repeat (40) @(negedge clock);
        rd(STATUS_ONE_ADDR);
        rd(STATUS_ONE_ADDR);
        // assist entry, fault exit, re-entry under held alert, host exit
        u_host_model.mode(1'b1, 1'b0);
        asst = 1'b1;
        settle();
        rd(STATUS_ONE_ADDR);
        check({5'h00, loops, aprof, sprof}, 8'h01);
        any_fault = 1'b1;
        asst = 1'b0;
        settle();
        any_fault = 1'b0;
        check({4'h0, assist, xflag, alert, loops}, 8'h07);
        u_host_model.mode(1'b0, 1'b0);
        settle();
        u_host_model.mode(1'b1, 1'b0);
        asst = 1'b1;
        settle();
        check({6'h00, assist, alert}, 8'h03);
        u_host_model.clear_exit();
        settle();
        check({6'h00, xflag, alert}, 8'h00);
        u_host_model.mode(1'b1, 1'b1);
        asst = 1'b0;
        settle();
        rd(STATUS_ONE_ADDR);
        check({5'h00, assist, loops, rev}, 8'h03);
        u_host_model.mode(1'b0, 1'b0);
        // register reset command drops a latched fault
        short_cond = 1'b1;
        settle();
        short_cond = 1'b0;
        settle();
        soft_rst = 1'b1;
        @(negedge clock);
        soft_rst = 1'b0;
        {sh, sh_seen} = 2'b00;
        rd(STATUS_ONE_ADDR);
        // gated core: a fault pulse while frozen never reaches the latch
        clk_en = 1'b0;
        short_cond = 1'b1;
        settle();
        short_cond = 1'b0;
        settle();
        clk_en = 1'b1;
        settle();
        rd(STATUS_ONE_ADDR);
        stop_test();
    end
endmodule
`default_nettype wire
